// ==== injector_command_gate_rail_pwm.v ====
// Operation
// - each driver module energises at most one of its channels at once.
// - any injection pulse is cut off after 5 ms even if still commanded.
// - two or more simultaneous commands on a module, direct or internal as its mode selects, hold all its channels off.
// - a PID loop on measured pressure sets a PWM duty to hold the rail setpoint.
// - the inlet metering valve and the optional rail bleed valve are driven by lowside PWM.
// - locking ties lowside 1 to 2 and 3 to 4 so each pair switches identically.
// - any of four analog inputs may be selected as pressure feedback.
// - loss of host communication leaves the last applied configuration running.
// - after power-up the block runs on stored default configuration without host action.
// - analog inputs are sampled every 15 ms and each sample feeds the loop.
// - in direct mode the output follows the active input, bounded by the maximum length.
`timescale 1ns/1ps
`default_nettype none
`include "inj_defines.vh"
module injector_command_gate_rail_pwm #(
    parameter MODULES = 4,
    parameter CHANS = 3,
    parameter MAX_PULSE_CYC = `MAX_PULSE_CYC,
    parameter SAMPLE_CYC = `SAMPLE_CYC
) (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire [MODULES*CHANS-1:0] direct_cmd_i,
    input wire [MODULES*CHANS-1:0] internal_cmd_i,
    input wire [MODULES*CHANS-1:0] invert_i,
    input wire [MODULES-1:0] internal_mode_i,
    input wire [4*`ADC_W-1:0] analog_in_i,
    input wire cfg_load_i,
    input wire [`ADC_W-1:0] cfg_setpoint_i,
    input wire [`GAIN_W-1:0] cfg_kp_i,
    input wire [`GAIN_W-1:0] cfg_ki_i,
    input wire [`GAIN_W-1:0] cfg_kd_i,
    input wire [1:0] cfg_fb_sel_i,
    input wire cfg_lock_i,
    input wire [`DUTY_W-1:0] cfg_bleed_duty_i,
    output wire [MODULES*CHANS-1:0] injector_driver_o,
    output reg lowside_out_1_o,
    output reg lowside_out_2_o,
    output reg lowside_out_3_o,
    output reg lowside_out_4_o,
    output reg [`DUTY_W-1:0] duty_o
);
    localparam CW = 32;
    localparam [`DUTY_W-1:0] DUTY_MAX = {`DUTY_W{1'b1}};

    // configuration: defaults from reset, replaced only by explicit load
    reg [`ADC_W-1:0] setpoint_ff;
    reg [`GAIN_W-1:0] kp_ff, ki_ff, kd_ff;
    reg [1:0] fb_sel_ff;
    reg lock_ff;
    reg [`DUTY_W-1:0] bleed_duty_ff;
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            setpoint_ff <= `DEF_SETPOINT;
            kp_ff <= `DEF_KP;
            ki_ff <= `DEF_KI;
            kd_ff <= `DEF_KD;
            fb_sel_ff <= `DEF_FB_SEL;
            lock_ff <= `DEF_LOCK;
            bleed_duty_ff <= {`DUTY_W{1'b0}};
        end else if (cfg_load_i) begin
            setpoint_ff <= cfg_setpoint_i;
            kp_ff <= cfg_kp_i;
            ki_ff <= cfg_ki_i;
            kd_ff <= cfg_kd_i;
            fb_sel_ff <= cfg_fb_sel_i;
            lock_ff <= cfg_lock_i;
            bleed_duty_ff <= cfg_bleed_duty_i;
        end
    end

    // command inputs come from pins: two-flop sync
    reg [MODULES*CHANS-1:0] cmd_s1_ff, cmd_s2_ff;
    // polarity delayed alongside the pins, else a polarity change fires a false pulse
    reg [MODULES*CHANS-1:0] inv_d1_ff, inv_d2_ff;
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_s1_ff <= {MODULES*CHANS{1'b0}};
            cmd_s2_ff <= {MODULES*CHANS{1'b0}};
            inv_d1_ff <= {MODULES*CHANS{1'b0}};
            inv_d2_ff <= {MODULES*CHANS{1'b0}};
        end else begin
            cmd_s1_ff <= direct_cmd_i;
            cmd_s2_ff <= cmd_s1_ff;
            inv_d1_ff <= invert_i;
            inv_d2_ff <= inv_d1_ff;
        end
    end

    genvar m;
    generate
        for (m = 0; m < MODULES; m = m + 1) begin : g_mod
            wire [CHANS-1:0] dir = cmd_s2_ff[m*CHANS +: CHANS] ^ inv_d2_ff[m*CHANS +: CHANS];
            wire [CHANS-1:0] req = internal_mode_i[m] ?
                internal_cmd_i[m*CHANS +: CHANS] : dir;
            // one-hot check: a request with more than one bit blocks the module
            wire single = (req != {CHANS{1'b0}}) && ((req & (req - 1'b1)) == {CHANS{1'b0}});
            reg [CHANS-1:0] prev_ff;
            reg [CHANS-1:0] drv_ff;
            reg [CW-1:0] cnt_ff;
            reg expired_ff;
            wire start = single && (req != prev_ff);
            assign injector_driver_o[m*CHANS +: CHANS] = drv_ff;
            always @(posedge clk_sys_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    prev_ff <= {CHANS{1'b0}};
                    cnt_ff <= {CW{1'b0}};
                    expired_ff <= 1'b0;
                    drv_ff <= {CHANS{1'b0}};
                end else begin
                    prev_ff <= req;
                    if (!single) begin
                        cnt_ff <= {CW{1'b0}};
                        expired_ff <= 1'b0;
                        drv_ff <= {CHANS{1'b0}};
                    end else if (start) begin
                        cnt_ff <= {{CW-1{1'b0}}, 1'b1};
                        expired_ff <= 1'b0;
                        drv_ff <= req;
                    end else if (expired_ff || cnt_ff >= MAX_PULSE_CYC) begin
                        // stays off until the command drops or changes
                        expired_ff <= 1'b1;
                        drv_ff <= {CHANS{1'b0}};
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                        drv_ff <= req;
                    end
                end
            end
        end
    endgenerate

    // analog sample tick and feedback selection
    reg [CW-1:0] tick_cnt_ff;
    wire tick = (tick_cnt_ff == SAMPLE_CYC - 1);
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_cnt_ff <= {CW{1'b0}};
        end else begin
            tick_cnt_ff <= tick ? {CW{1'b0}} : tick_cnt_ff + 1'b1;
        end
    end
    // all words synced before the mux; slow analog words are assumed steady,
    // a word caught mid-change is replaced at the next sample
    reg [4*`ADC_W-1:0] ain_s1_ff, ain_s2_ff;
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ain_s1_ff <= {(4*`ADC_W){1'b0}};
            ain_s2_ff <= {(4*`ADC_W){1'b0}};
        end else begin
            ain_s1_ff <= analog_in_i;
            ain_s2_ff <= ain_s1_ff;
        end
    end
    wire [`ADC_W-1:0] ain_sel = ain_s2_ff[fb_sel_ff*`ADC_W +: `ADC_W];
    wire [`ADC_W-1:0] sample;
    wire sample_vld;
    sample_store #(.W(`ADC_W)) u_store (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .wr_i(tick),
        .wdata_i(ain_sel),
        .rdata_o(sample),
        .valid_o(sample_vld)
    );

    // pid, one update per new sample
    reg signed [`ADC_W:0] err_prev_ff;
    reg signed [`ACC_W-1:0] integ_ff;
    wire signed [`ADC_W:0] err = $signed({1'b0, setpoint_ff}) - $signed({1'b0, sample});
    wire signed [`ACC_W-1:0] integ_nxt = integ_ff + $signed({1'b0, ki_ff}) * err;
    // integrator clamped too, so it cannot wind up past full scale
    wire signed [`ACC_W-1:0] integ_lim = (integ_nxt < 0) ? {`ACC_W{1'b0}} :
        (integ_nxt > ($signed({1'b0, DUTY_MAX}) <<< `GAIN_SHIFT)) ?
        ($signed({1'b0, DUTY_MAX}) <<< `GAIN_SHIFT) : integ_nxt;
    wire signed [`ACC_W-1:0] pid_sum = integ_lim + $signed({1'b0, kp_ff}) * err
        + $signed({1'b0, kd_ff}) * (err - err_prev_ff);
    wire signed [`ACC_W-1:0] pid_scaled = pid_sum >>> `GAIN_SHIFT;
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err_prev_ff <= {(`ADC_W+1){1'b0}};
            integ_ff <= {`ACC_W{1'b0}};
            duty_o <= {`DUTY_W{1'b0}};
        end else if (sample_vld) begin
            err_prev_ff <= err;
            integ_ff <= integ_lim;
            if (pid_scaled < 0) begin
                duty_o <= {`DUTY_W{1'b0}};
            end else if (pid_scaled > $signed({1'b0, DUTY_MAX})) begin
                duty_o <= DUTY_MAX;
            end else begin
                duty_o <= pid_scaled[`DUTY_W-1:0];
            end
        end
    end

    // lowside pwm: 1/2 inlet metering valve, 3/4 rail bleed valve
    reg [CW-1:0] pwm_cnt_ff;
    wire [CW-1:0] pwm_per = `PWM_PERIOD_CYC;
    wire [CW-1:0] imv_thr = (duty_o * pwm_per) >> `DUTY_W;
    wire [CW-1:0] bleed_thr = (bleed_duty_ff * pwm_per) >> `DUTY_W;
    wire inlet_metering_valve = (pwm_cnt_ff < imv_thr) || (duty_o == DUTY_MAX);
    wire rail_bleed_valve = (pwm_cnt_ff < bleed_thr) || (bleed_duty_ff == DUTY_MAX);
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pwm_cnt_ff <= {CW{1'b0}};
            lowside_out_1_o <= 1'b0;
            lowside_out_2_o <= 1'b0;
            lowside_out_3_o <= 1'b0;
            lowside_out_4_o <= 1'b0;
        end else begin
            pwm_cnt_ff <= (pwm_cnt_ff == pwm_per - 1) ? {CW{1'b0}} : pwm_cnt_ff + 1'b1;
            lowside_out_1_o <= inlet_metering_valve;
            lowside_out_3_o <= rail_bleed_valve;
            // unlocked: partner channel left idle rather than carrying half the load
            lowside_out_2_o <= lock_ff & inlet_metering_valve;
            lowside_out_4_o <= lock_ff & rail_bleed_valve;
        end
    end
endmodule // injector_command_gate_rail_pwm
`default_nettype wire

// ==== inj_defines.vh ====
`ifndef INJ_DEFINES_VH
`define INJ_DEFINES_VH
`define CLK_MHZ 200
`define MAX_PULSE_US 5000
`define MAX_PULSE_CYC (`MAX_PULSE_US * `CLK_MHZ)
`define SAMPLE_US 15000
`define SAMPLE_CYC (`SAMPLE_US * `CLK_MHZ)
`define ADC_W 12
`define DUTY_W 12
`define GAIN_W 8
`define GAIN_SHIFT 4
`define PWM_PERIOD_CYC 20000
`define DEF_SETPOINT 12'h0800
`define DEF_KP 8'h10
`define DEF_KI 8'h02
`define DEF_KD 8'h00
`define DEF_FB_SEL 2'h0
`define DEF_LOCK 1'b1
`define ACC_W 28
`endif

// ==== sample_store.v ====
`timescale 1ns/1ps
`default_nettype none
// one-word sample store, registered read data
module sample_store #(
    parameter W = 12
) (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire wr_i,
    input wire [W-1:0] wdata_i,
    output reg [W-1:0] rdata_o,
    output reg valid_o
);
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= {W{1'b0}};
            valid_o <= 1'b0;
        end else begin
            valid_o <= wr_i;
            if (wr_i) begin
                rdata_o <= wdata_i;
            end
        end
    end
endmodule // sample_store
`default_nettype wire

// ==== inj_cmd_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module inj_cmd_src (
    input wire logic clk_i,
    input wire logic [11:0] want_i,
    input wire logic [11:0] inv_i,
    output logic [11:0] pin_o
);
    logic [11:0] want_ff = 12'h000;
    // polarity applied at once so an idle active-low line never glitches active
    assign pin_o = want_ff ^ inv_i;
    always @(posedge clk_i) want_ff <= #1 want_i;
endmodule // inj_cmd_src
`default_nettype wire

// ==== injector_command_gate_rail_pwm_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module injector_command_gate_rail_pwm_sva #(
    parameter MODULES = 4,
    parameter CHANS = 3,
    parameter MAX_PULSE_CYC = 1000000,
    parameter SAMPLE_CYC = 3000000
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [MODULES*CHANS-1:0] direct_cmd_i,
    input wire logic [MODULES*CHANS-1:0] invert_i,
    input wire logic [MODULES-1:0] internal_mode_i,
    input wire logic cfg_load_i,
    input wire logic cfg_lock_i,
    input wire logic [MODULES*CHANS-1:0] injector_driver_o,
    input wire logic lowside_out_1_o,
    input wire logic lowside_out_2_o,
    input wire logic lowside_out_3_o,
    input wire logic lowside_out_4_o,
    input wire logic [11:0] duty_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    logic lock_ff;
    wire [MODULES*CHANS-1:0] act = direct_cmd_i ^ invert_i;
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) lock_ff <= 1'b1;
        else if (cfg_load_i) lock_ff <= cfg_lock_i;
    end
    logic [11:0] duty_prev_ff;
    int gap_ff;
    // cycles since duty last moved, saturating at one sample period
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            duty_prev_ff <= '0;
            gap_ff <= 0;
        end else begin
            duty_prev_ff <= duty_o;
            if (duty_o != duty_prev_ff) gap_ff <= 0;
            else if (gap_ff < SAMPLE_CYC) gap_ff <= gap_ff + 1;
        end
    end
    sequence duty_zero_s;
        (duty_o == 12'h000) [*4];
    endsequence
    sequence duty_full_s;
        (duty_o == 12'hfff) [*4];
    endsequence
    pwm_off_a: assert property (duty_zero_s |=> !lowside_out_1_o)
        else $error("valve drive high at zero duty");
    pwm_full_a: assert property (duty_full_s |=> lowside_out_1_o)
        else $error("valve drive low at full duty");
    lock_pair_a: assert property (lock_ff && $past(lock_ff, 2) |->
        lowside_out_2_o == lowside_out_1_o && lowside_out_4_o == lowside_out_3_o)
        else $error("locked pair differs");
    unlock_low_a: assert property (!lock_ff && !$past(lock_ff, 2) |->
        !lowside_out_2_o && !lowside_out_4_o) else $error("unlocked partner driven");
    sample_hold_a: assert property ($changed(duty_o) |=> $stable(duty_o) [*8])
        else $error("duty changed between samples");
    sample_rate_a: assert property ($changed(duty_o) |-> gap_ff >= SAMPLE_CYC - 1)
        else $error("duty updated faster than the sample period");
    for (genvar m = 0; m < MODULES; m++) begin : g_mod
        wire [CHANS-1:0] o = injector_driver_o[m*CHANS+:CHANS];
        wire [CHANS-1:0] a = act[m*CHANS+:CHANS];
        logic [CHANS-1:0] p_ff;
        int c_ff;
        // counts cycles of one unchanged drive, restarting on a new channel
        always @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                p_ff <= '0;
                c_ff <= 0;
            end else begin
                p_ff <= o;
                c_ff <= (o != 0 && o == p_ff) ? c_ff + 1 : int'(o != 0);
            end
        end
        one_hot_a: assert property ($onehot0(o))
            else $error("two channels driven");
        max_len_a: assert property (c_ff <= MAX_PULSE_CYC)
            else $error("pulse too long");
        multi_off_a: assert property ((!internal_mode_i[m] && !$onehot0(a)) [*4]
            |=> o == 0) else $error("channel on under multiple commands");
        release_off_a: assert property ((!internal_mode_i[m] && a == 0) [*4]
            |=> o == 0) else $error("channel on without command");
    end
endmodule // injector_command_gate_rail_pwm_sva
bind injector_command_gate_rail_pwm injector_command_gate_rail_pwm_sva #(.MODULES(MODULES),
    .CHANS(CHANS), .MAX_PULSE_CYC(MAX_PULSE_CYC), .SAMPLE_CYC(SAMPLE_CYC)) sva_i (
    .clk_sys_i, .resetn_i, .direct_cmd_i, .invert_i, .internal_mode_i, .cfg_load_i,
    .cfg_lock_i, .injector_driver_o, .lowside_out_1_o, .lowside_out_2_o, .lowside_out_3_o,
    .lowside_out_4_o, .duty_o);
`default_nettype wire

// ==== injector_command_gate_rail_pwm_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module injector_command_gate_rail_pwm_tb_top;
    logic clk_sys_i = 0, resetn_i = 0, cfg_load_i = 0, cfg_lock_i = 1;
    logic [11:0] want = 0, inv = 0, icmd = 0, setp = 12'h800, bleed = 0;
    logic [3:0] imode = 0;
    logic [47:0] ana = 0;
    logic [1:0] fsel = 0;
    wire [11:0] pins, drv, duty;
    wire ls1, ls2, ls3, ls4;
    int n_mismatch = 0, cmp_count = 0, k;
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    inj_cmd_src inj_cmd_src_i (.clk_i(clk_sys_i), .want_i(want), .inv_i(inv), .pin_o(pins));
    injector_command_gate_rail_pwm #(.MAX_PULSE_CYC(50), .SAMPLE_CYC(20))
        injector_command_gate_rail_pwm_i (.clk_sys_i, .resetn_i, .direct_cmd_i(pins),
        .internal_cmd_i(icmd), .invert_i(inv), .internal_mode_i(imode), .analog_in_i(ana),
        .cfg_load_i, .cfg_setpoint_i(setp), .cfg_kp_i(8'h10), .cfg_ki_i(8'h02),
        .cfg_kd_i(8'h00), .cfg_fb_sel_i(fsel), .cfg_lock_i, .cfg_bleed_duty_i(bleed),
        .injector_driver_o(drv), .lowside_out_1_o(ls1), .lowside_out_2_o(ls2),
        .lowside_out_3_o(ls3), .lowside_out_4_o(ls4), .duty_o(duty));
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic count_hi(input int b, input int n);
        repeat (n) begin
            step(1);
            k += (drv[b] === 1'b1);
        end
    endtask
    task automatic t_pulse(input int b, input int len, input int exp);
        k = 0;
        want[b] = 1;
        count_hi(b, len);
        want[b] = 0;
        count_hi(b, 8);
        `CHK(k, exp)
        `CHK(drv, 12'h000)
        $display("pulse test done on bit %0d", b);
    endtask
    task automatic t_multi;
        want = 12'h803; // module 3 fires beside a double command on module 0
        step(10);
        `CHK(drv, 12'h800)
        want = 12'h801;
        step(5);
        `CHK(drv, 12'h801)
        want = 0;
        step(5);
        $display("multi command test done");
    endtask
    task automatic t_internal;
        imode = 4'h4;
        icmd = 12'h100;
        k = 0;
        count_hi(8, 70);
        `CHK(k, 50)
        icmd = 12'h180;
        step(5);
        `CHK(drv, 12'h000)
        icmd = 0;
        imode = 0;
        $display("internal test done");
    endtask
    task automatic load;
        cfg_load_i = 1;
        step(1);
        cfg_load_i = 0;
    endtask
    task automatic t_rail;
        step(100);
        `CHK(duty, 12'hfff)
        ana = 48'h000f_ff00_0000;
        fsel = 1;
        setp = 12'hfff;
        bleed = 12'hfff;
        load();
        step(200);
        `CHK(duty, 12'hfff)
        `CHK({ls1, ls2, ls3, ls4}, 4'hf)
        fsel = 2;
        setp = 0;
        bleed = 0;
        cfg_lock_i = 0;
        load();
        step(400);
        `CHK(duty, 12'h000)
        `CHK({ls1, ls2, ls3, ls4}, 4'h0)
        setp = 12'hfff; // config ports change with no load strobe
        step(100);
        `CHK(duty, 12'h000)
        $display("rail loop test done");
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        step(5);
        resetn_i = 1;
        step(2);
        t_pulse(1, 20, 20);
        t_pulse(4, 80, 50);
        inv[3] = 1;
        step(4);
        t_pulse(3, 20, 20);
        t_multi();
        t_internal();
        t_rail();
        finish_test();
    end
    // whole run is about 1050 cycles, so 20 us means a hang
    initial begin
        #20000;
        n_mismatch++;
        finish_test();
    end
endmodule // injector_command_gate_rail_pwm_tb_top
`default_nettype wire
